// File: design/qddc_path.sv
// Per-channel decimating down-conversion path with burst output, four channels
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module qddc_path
   import qddc_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int TAPS = 8
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CHANNELS*qddc_pkg::SAMP_W-1:0] convEven,
   input wire logic [CHANNELS*qddc_pkg::SAMP_W-1:0] convOdd,
   input wire logic convValid,
   input wire logic trigPairAb,
   input wire logic trigPairCd,
   output logic [CHANNELS*qddc_pkg::SAMP_W-1:0] outI,
   output logic [CHANNELS*qddc_pkg::SAMP_W-1:0] outQ,
   output logic [CHANNELS-1:0] outValid,
   output logic [CHANNELS-1:0] outLowRes
);
   import qddc_pkg::*;

   logic [31:0] ctrl_r;
   logic [31:0] nco_r;
   logic [31:0] burst_r;
   logic [31:0] statusWord;
   logic [CHANNELS-1:0] burstActive;

   assign statusWord = {{(32-CHANNELS){1'b0}}, burstActive};

   qddc_regs u_regs (
      .clock(clock),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .statusWord(statusWord),
      .ctrl_r(ctrl_r),
      .nco_r(nco_r),
      .burst_r(burst_r)
   );

   logic hiPass;
   logic [3:0] modeSel;
   logic dec4;
   logic realOut;
   logic trigFromPin;
   logic [15:0] hiCount;
   logic [15:0] loCount;
   assign hiPass = ctrl_r[CTRL_HIPASS];
   assign modeSel = ctrl_r[CTRL_MODE_LO +: 4];
   assign dec4 = ctrl_r[CTRL_DEC4]; // One factor for all channels
   assign realOut = ctrl_r[CTRL_REALOUT];
   assign trigFromPin = ctrl_r[CTRL_TRIGPIN];
   assign hiCount = burst_r[BURST_HI_LO +: 16];
   assign loCount = burst_r[BURST_LO_LO +: 16];

   // ==========================================
   // Shared oscillator phase, one step per half-rate sample
   logic [NCO_W-1:0] phase_r;
   logic [1:0] quad;
   logic halfPhase_r;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase_r <= '0;
         halfPhase_r <= 1'b0;
      end else if (convValid) begin
         halfPhase_r <= ~halfPhase_r;
         if (halfPhase_r) begin
            // Mode 0 steps -fs/4; otherwise 16-bit tuning word
            phase_r <= phase_r + ((modeSel == MODE_FIXED) ? 16'hC000 : nco_r[NCO_W-1:0]);
         end
      end
   end
   // Coarse quadrant mixer keeps logic small at the cost of spur level
   assign quad = phase_r[NCO_W-1 -: 2];

   // Second-stage decimation counter: output every 2 or 4 half-rate samples
   logic [1:0] decCnt_r;
   logic stage2Tick;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         decCnt_r <= 2'd0;
      end else if (convValid && halfPhase_r) begin
         decCnt_r <= (decCnt_r == (dec4 ? 2'd3 : 2'd1)) ? 2'd0 : decCnt_r + 2'd1;
      end
   end
   assign stage2Tick = convValid && halfPhase_r && (decCnt_r == (dec4 ? 2'd3 : 2'd1));

   logic [1:0] realPh_r;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         realPh_r <= 2'd0;
      end else if (stage2Tick) begin
         realPh_r <= realPh_r + 2'd1; // fout/4 rotation
      end
   end

   function automatic logic signed [SAMP_W-1:0] sat(input logic signed [SAMP_W+4:0] v);
      if (v > $signed({5'd0, 1'b0, {(SAMP_W-1){1'b1}}})) begin
         return {1'b0, {(SAMP_W-1){1'b1}}};
      end else if (v < $signed({5'h1F, 1'b1, {(SAMP_W-1){1'b0}}})) begin
         return {1'b1, {(SAMP_W-1){1'b0}}};
      end
      return v[SAMP_W-1:0];
   endfunction

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         logic signed [SAMP_W-1:0] evenS;
         logic signed [SAMP_W-1:0] oddS;
         logic signed [SAMP_W-1:0] taps_r [TAPS];
         logic signed [SAMP_W+4:0] acc;
         logic signed [SAMP_W-1:0] fs1_r;
         logic fs1Valid_r;
         logic pairBurst;
         logic pairTrig;
         assign evenS = convEven[ch*SAMP_W +: SAMP_W];
         assign oddS = convOdd[ch*SAMP_W +: SAMP_W];
         assign pairBurst = (ch < 2) ? ctrl_r[CTRL_BURST_AB] : ctrl_r[CTRL_BURST_CD];
         assign pairTrig = (ch < 2) ? trigPairAb : trigPairCd;

         // Interleave both converters into one full-rate delay line
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               for (int k = 0; k < TAPS; k++) begin
                  taps_r[k] <= '0;
               end
            end else if (convValid) begin
               for (int k = TAPS-1; k >= 2; k--) begin
                  taps_r[k] <= taps_r[k-2];
               end
               taps_r[1] <= evenS;
               taps_r[0] <= oddS;
            end
         end

         // Half-band style sum; odd taps negated for the high-pass image
         always_comb begin
            acc = '0;
            for (int k = 0; k < TAPS; k++) begin
               if (hiPass && k[0]) begin
                  acc = acc - (SAMP_W+5)'(taps_r[k]);
               end else begin
                  acc = acc + (SAMP_W+5)'(taps_r[k]);
               end
            end
         end

         // Always one output per two converter pairs: 1 GSPS to 500 MSPS
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               fs1_r <= '0;
               fs1Valid_r <= 1'b0;
            end else begin
               fs1Valid_r <= convValid && halfPhase_r;
               if (convValid && halfPhase_r) begin
                  fs1_r <= sat(acc >>> 3);
               end
            end
         end

         // Quadrant mix to I/Q, then boxcar average over the decimation span
         logic signed [SAMP_W-1:0] mixI;
         logic signed [SAMP_W-1:0] mixQ;
         logic signed [SAMP_W+4:0] accI_r;
         logic signed [SAMP_W+4:0] accQ_r;
         always_comb begin
            unique case (quad)
               2'd0: begin mixI = fs1_r; mixQ = '0; end
               2'd1: begin mixI = '0; mixQ = -fs1_r; end
               2'd2: begin mixI = -fs1_r; mixQ = '0; end
               2'd3: begin mixI = '0; mixQ = fs1_r; end
            endcase
         end
         always_ff @(posedge clock) begin
            if (sys_rst || stage2Tick) begin
               accI_r <= '0;
               accQ_r <= '0;
            end else if (fs1Valid_r) begin
               accI_r <= accI_r + (SAMP_W+5)'(mixI);
               accQ_r <= accQ_r + (SAMP_W+5)'(mixQ);
            end
         end

         // Burst sequencer: high-res then low-res counts, auto or pin trigger
         qddc_burst_t bState_r;
         logic [15:0] bCnt_r;
         always_ff @(posedge clock) begin
            if (sys_rst || !pairBurst) begin
               bState_r <= QDDC_IDLE;
               bCnt_r <= 16'd0;
            end else if (fs1Valid_r) begin
               unique case (bState_r)
                  QDDC_IDLE: begin
                     if (!trigFromPin || pairTrig) begin
                        bState_r <= QDDC_HIGH;
                        bCnt_r <= 16'd0;
                     end
                  end
                  QDDC_HIGH: begin
                     bCnt_r <= bCnt_r + 16'd1;
                     if (bCnt_r + 16'd1 >= hiCount) begin
                        bState_r <= QDDC_LOW;
                        bCnt_r <= 16'd0;
                     end
                  end
                  QDDC_LOW: begin
                     bCnt_r <= bCnt_r + 16'd1;
                     if (bCnt_r + 16'd1 >= loCount) begin
                        bState_r <= QDDC_IDLE;
                     end
                  end
               endcase
            end
         end
         assign burstActive[ch] = (bState_r != QDDC_IDLE);

         // Output select: burst bypasses stage two, else decimated I/Q or real
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               outI[ch*SAMP_W +: SAMP_W] <= '0;
               outQ[ch*SAMP_W +: SAMP_W] <= '0;
               outValid[ch] <= 1'b0;
               outLowRes[ch] <= 1'b0;
            end else if (pairBurst) begin
               outValid[ch] <= fs1Valid_r && (bState_r != QDDC_IDLE);
               outLowRes[ch] <= (bState_r == QDDC_LOW);
               outQ[ch*SAMP_W +: SAMP_W] <= '0;
               if (bState_r == QDDC_LOW) begin
                  // Keep top 9 bits only
                  outI[ch*SAMP_W +: SAMP_W] <= {fs1_r[SAMP_W-1 -: LOWRES_W],
                                                 {(SAMP_W-LOWRES_W){1'b0}}};
               end else begin
                  outI[ch*SAMP_W +: SAMP_W] <= fs1_r;
               end
            end else begin
               outValid[ch] <= stage2Tick;
               outLowRes[ch] <= 1'b0;
               if (realOut) begin
                  // Real output: I,-Q,-I,Q pattern
                  unique case (realPh_r)
                     2'd0: outI[ch*SAMP_W +: SAMP_W] <= sat(accI_r >>> (dec4 ? 2 : 1));
                     2'd1: outI[ch*SAMP_W +: SAMP_W] <= sat(-(accQ_r >>> (dec4 ? 2 : 1)));
                     2'd2: outI[ch*SAMP_W +: SAMP_W] <= sat(-(accI_r >>> (dec4 ? 2 : 1)));
                     2'd3: outI[ch*SAMP_W +: SAMP_W] <= sat(accQ_r >>> (dec4 ? 2 : 1));
                  endcase
                  outQ[ch*SAMP_W +: SAMP_W] <= '0;
               end else begin
                  // Complex I/Q out
                  outI[ch*SAMP_W +: SAMP_W] <= sat(accI_r >>> (dec4 ? 2 : 1));
                  outQ[ch*SAMP_W +: SAMP_W] <= sat(accQ_r >>> (dec4 ? 2 : 1));
               end
            end
         end

         // ==========================================
         // Checks
         burst_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
            (pairBurst && !burstActive[ch] && $past(pairBurst)) |=> !outValid[ch]
            || $past(fs1Valid_r))
            else $error("burst output without active burst");
         lowres_pad_a: assert property (@(posedge clock) disable iff (sys_rst)
            (outValid[ch] && outLowRes[ch]) |-> outI[ch*SAMP_W +: SAMP_W-LOWRES_W] == '0)
            else $error("low-res sample not truncated");
      end
   endgenerate

   sequence half_tick_s;
      convValid && halfPhase_r;
   endsequence
   fs1_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
      half_tick_s |=> g_chan[0].fs1Valid_r)
      else $error("first stage missed a sample");
   dec_span_a: assert property (@(posedge clock) disable iff (sys_rst)
      (stage2Tick && !dec4 && $stable(dec4)) |-> (decCnt_r == 2'd1))
      else $error("decimate-by-2 span wrong");
   fs1_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
      g_chan[0].fs1Valid_r |=> !g_chan[0].fs1Valid_r)
      else $error("first stage not halving rate");
   mode0_step_a: assert property (@(posedge clock) disable iff (sys_rst)
      (half_tick_s and (modeSel == MODE_FIXED)) |=> (phase_r == $past(phase_r) + 16'hC000))
      else $error("fixed mixer step wrong");
   nco_step_a: assert property (@(posedge clock) disable iff (sys_rst)
      (half_tick_s and (modeSel == MODE_NCO)) |=> (phase_r == $past(phase_r) + $past(nco_r[15:0])))
      else $error("oscillator step wrong");
   dec_valid_a: assert property (@(posedge clock) disable iff (sys_rst)
      (stage2Tick && !ctrl_r[CTRL_BURST_AB]) |=> outValid[0])
      else $error("decimated output strobe missing");
endmodule

// File: design/qddc_pkg.sv
// Constants and types shared by the down-conversion path and its register bank
// Contract
// - Merge two interleaved half-rate converter streams into one full-rate stream per channel.
// - First decimate-by-2 stage is always applied and cannot be bypassed.
// - First stage selects low-pass or high-pass response; low-pass after reset.
// - First stage aims at 45% passband, under 0.2 dB ripple, about 40 dB stopband.
// - First stage halves converter rate, 1 GSPS to 500 MSPS, feeding later stages.
// - A 16-bit NCO mixes first-stage data ahead of the second stage.
// - Second stage does quadrature demodulation and decimates by 2 or 4.
// - Second-stage filter passband is 81.4% of its output sample rate.
// - Optional real output by quadrature modulation at a quarter of output rate.
// - Default mode 0 mixes with fixed minus fs/4 and outputs complex I/Q.
// - Burst mode outputs first-stage data directly, bypassing the second stage.
// - Burst mode 8 interleaves 14-bit high and 9-bit low resolution samples; code enables burst with CTRL_BURST_AB and CTRL_BURST_CD instead.
// - Burst enabled by programming, with sample counts and auto or pin trigger.
// - Burst or decimation mode is chosen per channel pair, AB and CD.
package qddc_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_NCO = 8'h04;
   localparam logic [7:0] ADDR_BURST = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // ==========================================
   // Control fields
   localparam int CTRL_HIPASS = 0;
   localparam int CTRL_MODE_LO = 1;
   localparam int CTRL_DEC4 = 5;
   localparam int CTRL_REALOUT = 6;
   localparam int CTRL_TRIGPIN = 7;
   localparam int CTRL_BURST_AB = 8;
   localparam int CTRL_BURST_CD = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] NCO_RESET = 32'h0000_0000;
   localparam logic [31:0] BURST_RESET = 32'h0008_0008;
   localparam int BURST_HI_LO = 0;
   localparam int BURST_LO_LO = 16;
   // ==========================================
   // Data formats and modes
   localparam int SAMP_W = 14;
   localparam int LOWRES_W = 9;
   localparam int NCO_W = 16;
   localparam logic [3:0] MODE_FIXED = 4'h0;
   localparam logic [3:0] MODE_NCO = 4'h1;
   localparam logic [3:0] MODE_BURST = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      QDDC_IDLE = 3'b001,
      QDDC_HIGH = 3'b010,
      QDDC_LOW = 3'b100
   } qddc_burst_t;
endpackage

// File: design/qddc_regs.sv
// AXI4-Lite register bank for the down-conversion path
`timescale 1ns/1ps
module qddc_regs
   import qddc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] statusWord,
   output logic [31:0] ctrl_r,
   output logic [31:0] nco_r,
   output logic [31:0] burst_r
);
   logic awHeld_r;
   logic wHeld_r;
   logic [7:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;

   function automatic logic mapped(input logic [7:0] a);
      return (a == ADDR_CTRL) || (a == ADDR_NCO) || (a == ADDR_BURST) || (a == ADDR_STATUS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[8*i +: 8] = d[8*i +: 8];
         end
      end
      return m;
   endfunction

   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // ==========================================
   // Write path: address and data in either order
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (awHeld_r && wHeld_r) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RESET;
         nco_r <= NCO_RESET;
         burst_r <= BURST_RESET;
      end else if (awHeld_r && wHeld_r) begin
         unique case (awAddr_r)
            ADDR_CTRL: ctrl_r <= merge(ctrl_r, wData_r, wStrb_r);
            ADDR_NCO: nco_r <= merge(nco_r, wData_r, wStrb_r);
            ADDR_BURST: burst_r <= merge(burst_r, wData_r, wStrb_r);
            default: ;
         endcase
      end
   end

   // ==========================================
   // Read path: one cycle to the answer
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            ADDR_CTRL: s_axi_rdata <= ctrl_r;
            ADDR_NCO: s_axi_rdata <= nco_r;
            ADDR_BURST: s_axi_rdata <= burst_r;
            ADDR_STATUS: s_axi_rdata <= statusWord;
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   bvalid_follows_a: assert property (@(posedge clock) disable iff (sys_rst)
      (awHeld_r && wHeld_r) |=> s_axi_bvalid)
      else $error("write response missing");
endmodule

// File: sim/qddc_sink.sv
// Downstream framer stand-in that takes one sample per strobe
`timescale 1ns/1ps
module qddc_sink #(
   parameter int CHANNELS = 4
)
(
   input wire logic clock,
   input wire logic clear,
   input wire logic realMode,
   input wire logic [CHANNELS*qddc_pkg::SAMP_W-1:0] outI,
   input wire logic [CHANNELS*qddc_pkg::SAMP_W-1:0] outQ,
   input wire logic [CHANNELS-1:0] outValid,
   input wire logic [CHANNELS-1:0] outLowRes,
   output logic [CHANNELS*16-1:0] strobeCount,
   output logic [CHANNELS*16-1:0] lowCount,
   output logic [CHANNELS-1:0] faultSeen
);
   import qddc_pkg::*;
   // ==========================================
   // Sample intake, no back-pressure possible
   always_ff @(posedge clock) begin
      for (int c = 0; c < CHANNELS; c++) begin
         if (clear) begin
            strobeCount[c*16 +: 16] <= 16'h0000;
            lowCount[c*16 +: 16] <= 16'h0000;
            faultSeen[c] <= 1'h0;
         end else if (outValid[c]) begin
            strobeCount[c*16 +: 16] <= strobeCount[c*16 +: 16] + 16'h0001;
            // Low-res words carry only the top 9 bits
            if (outLowRes[c]) begin
               lowCount[c*16 +: 16] <= lowCount[c*16 +: 16] + 16'h0001;
               faultSeen[c] <= faultSeen[c] | (outI[c*SAMP_W +: 5] != 5'h00);
            end
            if (realMode && outQ[c*SAMP_W +: SAMP_W] != '0) begin
               faultSeen[c] <= 1'h1;
            end
         end
      end
   end
endmodule

// File: sim/test_quad_channel_ddc_burst_path.sv
// Self-checking bench for the four-channel down-conversion path
`timescale 1ns/1ps
module test_quad_channel_ddc_burst_path;
   import qddc_pkg::*;
   logic clock, sys_rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, convValid, trigAb, trigCd, sinkClear, realOn;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [4*SAMP_W-1:0] convEven, convOdd, outI, outQ;
   logic [3:0] outValid, outLowRes, faultSeen;
   logic [63:0] strobeCount, lowCount;
   int err_total, comparisons, cycles;
   qddc_path qddc_path_i (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .convEven(convEven), .convOdd(convOdd), .convValid(convValid), .trigPairAb(trigAb),
      .trigPairCd(trigCd), .outI(outI), .outQ(outQ), .outValid(outValid),
      .outLowRes(outLowRes));
   qddc_sink qddc_sink_i (.clock(clock), .clear(sinkClear), .realMode(realOn), .outI(outI),
      .outQ(outQ), .outValid(outValid), .outLowRes(outLowRes), .strobeCount(strobeCount),
      .lowCount(lowCount), .faultSeen(faultSeen));
   // ==========================================
   // Clock, reset and hang guard
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmpWord(input logic [31:0] act, input logic [31:0] exp);
      comparisons++;
      if (act !== exp) begin
         err_total++;
         $display("ERROR t=%0t act=%h exp=%h", $time, act, exp);
      end
   endtask
   task automatic cmpResp(input logic [1:0] act, input logic [1:0] exp);
      comparisons++;
      if (act !== exp) begin
         err_total++;
         $display("ERROR t=%0t resp act=%h exp=%h", $time, act, exp);
      end
   endtask
   // ==========================================
   // Bus cycles: handshakes judged at the negedge, released after the edge
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awHit, wHit, bHit;
      bHit = 1'h0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!bHit) begin
         @(negedge clock);
         awHit = awvalid & awready;
         wHit = wvalid & wready;
         bHit = bvalid & bready;
         r = bresp;
         @(posedge clock);
         if (awHit) awvalid <= 1'h0;
         if (wHit) wvalid <= 1'h0;
      end
      bready <= 1'h0;
   endtask
   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arHit, rHit;
      rHit = 1'h0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!rHit) begin
         @(negedge clock);
         arHit = arvalid & arready;
         rHit = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge clock);
         if (arHit) arvalid <= 1'h0;
      end
      rready <= 1'h0;
   endtask
   task automatic checkReg(input logic [7:0] a, input logic [31:0] exp);
      axiRead(a, rd, rs);
      cmpResp(rs, RESP_OKAY);
      cmpWord(rd, exp);
   endtask
   // Program control and start counting afresh
   task automatic setMode(input logic [31:0] v);
      axiWrite(ADDR_CTRL, v, rs);
      cmpResp(rs, RESP_OKAY);
      sinkClear <= 1'h1;
      @(posedge clock);
      sinkClear <= 1'h0;
   endtask
   // Ramp keeps the filters busy; drain long enough for the pipe
   task automatic feed(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge clock);
         convValid <= 1'h1;
         convEven <= {4{14'(k * 37)}};
         convOdd <= {4{14'(k * 53 + 5)}};
      end
      @(posedge clock);
      convValid <= 1'h0;
      repeat (40) @(posedge clock);
   endtask
   function automatic logic [31:0] cnt(input int c);
      return {16'h0000, strobeCount[c*16 +: 16]};
   endfunction
   // ==========================================
   // Scenarios
   task automatic testRegisters();
      checkReg(ADDR_CTRL, 32'h0000_0000);
      checkReg(ADDR_NCO, 32'h0000_0000);
      checkReg(ADDR_BURST, 32'h0008_0008);
      axiWrite(ADDR_NCO, 32'h0000_ABCD, rs);
      checkReg(ADDR_NCO, 32'h0000_ABCD);
      axiWrite(8'h10, 32'h1234_5678, rs);
      cmpResp(rs, RESP_SLVERR);
      axiRead(8'h10, rd, rs);
      cmpResp(rs, RESP_SLVERR);
      cmpWord(rd, 32'h0000_0000);
   endtask
   task automatic testDecimate();
      for (int d = 0; d < 2; d++) begin
         setMode(d ? 32'h0000_0020 : 32'h0000_0000);
         feed(64);
         for (int c = 0; c < 4; c++) cmpWord(cnt(c), d ? 32'h8 : 32'h10);
      end
      // High-pass response with the tunable oscillator, still decimate-by-2
      setMode(32'h0000_0003);
      feed(32);
      cmpWord(cnt(1), 32'h8);
      realOn <= 1'h1;
      setMode(32'h0000_0040);
      feed(32);
      cmpWord(cnt(0), 32'h8);
      cmpWord({28'h0, faultSeen}, 32'h0);
      realOn <= 1'h0;
   endtask
   task automatic testBurst();
      axiWrite(ADDR_BURST, 32'h0002_0002, rs);
      setMode(32'h0000_0100);
      feed(32);
      // Auto trigger spends one sample re-arming after each low segment
      cmpWord(cnt(0), 32'hC);
      cmpWord(cnt(2), 32'h8);
      cmpWord({31'h0, lowCount[15:0] != 16'h0}, 32'h1);
      cmpWord({28'h0, faultSeen}, 32'h0);
      setMode(32'h0000_0280);
      feed(32);
      cmpWord(cnt(2), 32'h0);
      cmpWord(cnt(0), 32'h8);
      trigCd <= 1'h1;
      setMode(32'h0000_0280);
      feed(32);
      cmpWord({31'h0, cnt(2) != 32'h0}, 32'h1);
      checkReg(ADDR_STATUS, 32'h0000_000C);
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, convValid, trigAb, trigCd} = 8'h00;
      {sinkClear, realOn, awaddr, araddr, wdata} = '0;
      convEven = '0;
      convOdd = '0;
      err_total = 0;
      comparisons = 0;
      cycles = 0;
      sys_rst = 1'h1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'h0;
      testRegisters();
      testDecimate();
      testBurst();
      test_done();
   end
endmodule
